//--- shared/tape_panel_pkg.sv
// Constants and types for the tape operator panel sequencer
package tape_panel_pkg;
    // Switch positions in the press vector
    localparam int NUM_SW      = 8;
    localparam int SW_ONLINE   = 0;
    localparam int SW_RESET    = 1;
    localparam int SW_TEST     = 2;
    localparam int SW_STEP     = 3;
    localparam int SW_EXECUTE  = 4;
    localparam int SW_SERVICE  = 5;
    localparam int SW_LOADREW  = 6;
    localparam int SW_UNLOAD   = 7;
    // Timing
    localparam int CLK_HZ         = 250_000_000;
    localparam int CYC_PER_MS     = CLK_HZ / 1000;
    localparam int COMP_DELAY_MS  = 1000;
    localparam int PWROFF_LAMP_MS = 200;
    localparam int DEBOUNCE_MS    = 10;
    localparam int OVERRUN_FT     = 40;
    localparam int TMR_W          = 32;
    localparam int FT_W           = 8;
    // Display codes, two BCD digits
    localparam logic [7:0] TEST_FIRST = 8'h01;
    localparam logic [7:0] TEST_LAST  = 8'h99;
    localparam logic [7:0] CODE_NONE  = 8'h00;
    typedef enum logic [1:0] {
        P_OFFLAMP = 2'b00,
        P_HEALTH  = 2'b01,
        P_READY   = 2'b10
    } pwr_t;
    typedef enum logic [2:0] {
        M_IDLE   = 3'b000,
        M_COMP   = 3'b001,
        M_FWD    = 3'b010,
        M_REV    = 3'b011,
        M_UNLOAD = 3'b100
    } motion_t;
endpackage

//--- shared/panel_link_if.sv
// Press pulses and delay timer handshake inside the sequencer
`timescale 1ns/1ps
`default_nettype none
interface panel_link_if #(
    parameter int NSW = 8,
    parameter int TW  = 32
);
    logic [NSW-1:0] press;
    logic           tmrStart;
    logic [TW-1:0]  tmrLoad;
    logic           tmrDone;
    modport deb (output press);
    modport tmr (input tmrStart, input tmrLoad, output tmrDone);
    modport ctl (input press, input tmrDone, output tmrStart, output tmrLoad);
endinterface
`default_nettype wire

//--- hw/switch_debounce.sv
// Panel switch synchroniser, debouncer and press pulse former
`timescale 1ns/1ps
`default_nettype none
module switch_debounce
    import tape_panel_pkg::*;
#(
    parameter int NSW       = NUM_SW,
    parameter int DB_CYCLES = DEBOUNCE_MS * CYC_PER_MS
) (
    input  wire logic           mclk,
    input  wire logic           rst,
    input  wire logic           clkEn,
    input  wire logic [NSW-1:0] swRaw,
    panel_link_if.deb           link
);
    localparam int CW = $clog2(DB_CYCLES + 1);
    logic [NSW-1:0] s1_q, s2_q, s3_q;
    logic [NSW-1:0] lvl_q, lvl_d;
    logic [NSW-1:0] press_q, press_d;
    logic [CW-1:0]  cnt_q [NSW];
    logic [CW-1:0]  cnt_d [NSW];

    // Level must hold for the whole window; any bounce restarts it
    always_comb begin
        lvl_d = lvl_q;
        press_d = '0;
        for (int i = 0; i < NSW; i++) begin
            cnt_d[i] = '0;
            if (s2_q[i] == s3_q[i] && s3_q[i] != lvl_q[i]) begin
                if (cnt_q[i] == CW'(DB_CYCLES - 1)) begin
                    lvl_d[i] = s3_q[i];
                    press_d[i] = s3_q[i];
                end else begin
                    cnt_d[i] = cnt_q[i] + 1'b1;
                end
            end
        end
    end

    // Three-stage synchroniser and filter state
    always_ff @(posedge mclk) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            lvl_q <= '0;
            press_q <= '0;
            for (int i = 0; i < NSW; i++) cnt_q[i] <= '0;
        end else if (clkEn) begin
            s1_q <= swRaw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= lvl_d;
            press_q <= press_d;
            for (int i = 0; i < NSW; i++) cnt_q[i] <= cnt_d[i];
        end
    end

    assign link.press = press_q;
endmodule
`default_nettype wire

//--- hw/delay_timer.sv
// Down-counting delay timer with a one-cycle done pulse
`timescale 1ns/1ps
`default_nettype none
module delay_timer
    import tape_panel_pkg::*;
#(
    parameter int TW = TMR_W
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic clkEn,
    panel_link_if.tmr link
);
    logic [TW-1:0] cnt_q, cnt_d;
    logic          run_q, run_d;
    logic          done_q, done_d;

    // A new start restarts the count
    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        done_d = 1'b0;
        if (link.tmrStart) begin
            cnt_d = link.tmrLoad;
            run_d = 1'b1;
        end else if (run_q) begin
            if (cnt_q <= TW'(1)) begin
                run_d = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            done_q <= 1'b0;
        end else if (clkEn) begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            done_q <= done_d;
        end
    end

    assign link.tmrDone = done_q;
endmodule
`default_nettype wire

//--- hw/tape_panel_sequencer.sv
// Operator panel mode, lamp and tape motion sequencer
`timescale 1ns/1ps
`default_nettype none
// Contract
// - On-line press with tape loaded puts transport on-line under host.
// - On-line lamp lit exactly while transport is on-line.
// - Reset press forces off-line, stops motion, clears error status.
// - Hard control faults survive reset press; only power cycle clears.
// - Reset lamp lit on error or at diagnostic test completion.
// - High-density lamp lit while GCR recording is selected.
// - Diagnostic mode shows display with test number and results.
// - With reset lamp lit, display shows fault or failure code.
// - Diagnostics lamp lit while in diagnostic mode.
// - Test press enters diagnostic mode only when not on-line.
// - Step press in diagnostic mode advances test number.
// - Execute press in diagnostic mode starts the shown test.
// - Service press in diagnostic mode starts maintenance diagnostics.
// - Power-up: power-off lamp briefly, then power lamps, health check.
// - Load starts compressor, waits one second, then moves forward.
// - Load stops forward motion as soon as start marker is seen.
// - No marker: forward 40 feet, reverse to marker, stop, lamp.
// - On-line press during load is held until the load completes.
// - Unload drives reverse until tape clears reel and path.
// - Writes need write ring present; reads always allowed.
// - Write-protect lamp lit whenever no ring is sensed.
// - After load or rewind select 25 ips mode and position.
module tape_panel_sequencer
    import tape_panel_pkg::*;
#(
    parameter int DB_CYCLES     = DEBOUNCE_MS * CYC_PER_MS,
    parameter int COMP_CYCLES   = COMP_DELAY_MS * CYC_PER_MS,
    parameter int PWROFF_CYCLES = PWROFF_LAMP_MS * CYC_PER_MS,
    parameter int OVERRUN_FEET  = OVERRUN_FT
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              clkEn,
    input  wire logic [NUM_SW-1:0] swRaw,
    input  wire logic              markerPin,
    input  wire logic              ringPin,
    input  wire logic              tapeThreaded,
    input  wire logic              tapeClear,
    input  wire logic              footPulse,
    input  wire logic              gcrMode,
    input  wire logic              healthDone,
    input  wire logic              faultEvt,
    input  wire logic [7:0]        faultCode,
    input  wire logic              hardEvt,
    input  wire logic [7:0]        hardCode,
    input  wire logic              diagEnd,
    input  wire logic [7:0]        diagResult,
    input  wire logic              hostWriteReq,
    input  wire logic              hostReadReq,
    output logic                   lampOnLine,
    output logic                   lampReset,
    output logic                   lampHighDensity,
    output logic                   lampDiag,
    output logic                   lampPowerOff,
    output logic                   lampPowerOn,
    output logic                   lampWriteProtect,
    output logic                   lampTapeStart,
    output logic                   dispOn,
    output logic [7:0]             dispCode,
    output logic                   compressorOn,
    output logic                   motorFwd,
    output logic                   motorRev,
    output logic                   hostCtlEn,
    output logic                   writeGrant,
    output logic                   readGrant,
    output logic                   healthStart,
    output logic                   diagStart,
    output logic                   serviceStart,
    output logic [7:0]             testNum,
    output logic                   speed25Sel,
    output logic                   positionStart
);
    panel_link_if #(.NSW(NUM_SW), .TW(TMR_W)) link ();

    switch_debounce #(.NSW(NUM_SW), .DB_CYCLES(DB_CYCLES)) uDeb (
        .mclk  (mclk),
        .rst   (rst),
        .clkEn (clkEn),
        .swRaw (swRaw),
        .link  (link)
    );

    delay_timer #(.TW(TMR_W)) uTmr (
        .mclk  (mclk),
        .rst   (rst),
        .clkEn (clkEn),
        .link  (link)
    );

    pwr_t          pwr_q, pwr_d;
    motion_t       mot_q, mot_d;
    logic [1:0]    p1_q, p2_q, p3_q, pLvl_q, pLvl_d;
    logic          started_q, started_d, tStart_q, tStart_d;
    logic [TMR_W-1:0] tLoad_q, tLoad_d;
    logic [FT_W-1:0] feet_q, feet_d;
    logic          onLine_q, onLine_d, diag_q, diag_d;
    logic          loaded_q, loaded_d, pend_q, pend_d;
    logic          err_q, err_d, hard_q, hard_d, done_q, done_d;
    logic [7:0]    errCode_q, errCode_d, hardC_q, hardC_d;
    logic [7:0]    result_q, result_d, test_q, test_d;
    logic          mark_q, mark_d, spd_q, spd_d;
    logic [21:0]   out_q, out_d;
    logic [7:0]    disp_q, disp_d;
    logic          ready, markerSeen, ringOk, loadBusy;
    logic          pOn, pRst, pTest, pStep, pExe, pSvc, pLoad, pUnl;

    // Pin levels count once stages two and three agree
    assign markerSeen = pLvl_q[0];
    assign ringOk = pLvl_q[1];
    assign ready = (pwr_q == P_READY);
    assign loadBusy = (mot_q == M_COMP) || (mot_q == M_FWD)
                   || (mot_q == M_REV);
    assign pOn   = link.press[SW_ONLINE];
    assign pRst  = link.press[SW_RESET];
    assign pTest = link.press[SW_TEST];
    assign pStep = link.press[SW_STEP];
    assign pExe  = link.press[SW_EXECUTE];
    assign pSvc  = link.press[SW_SERVICE];
    assign pLoad = link.press[SW_LOADREW];
    assign pUnl  = link.press[SW_UNLOAD];
    assign link.tmrStart = tStart_q;
    assign link.tmrLoad = tLoad_q;

    // BCD step with wrap back to the first test
    function automatic logic [7:0] bcdNext(input logic [7:0] v);
        logic [7:0] r;
        r = v;
        if (v >= TEST_LAST) r = TEST_FIRST;
        else if (v[3:0] == 4'h9) r = {v[7:4] + 4'h1, 4'h0};
        else r = {v[7:4], v[3:0] + 4'h1};
        return r;
    endfunction

    // Next state: power and motion first, then switches, then error capture
    always_comb begin
        pwr_d = pwr_q;
        mot_d = mot_q;
        pLvl_d = pLvl_q;
        started_d = 1'b1;
        tStart_d = 1'b0;
        tLoad_d = tLoad_q;
        feet_d = feet_q;
        onLine_d = onLine_q;
        diag_d = diag_q;
        loaded_d = loaded_q;
        pend_d = pend_q;
        err_d = err_q;
        hard_d = hard_q;
        done_d = done_q;
        errCode_d = errCode_q;
        hardC_d = hardC_q;
        result_d = result_q;
        test_d = test_q;
        mark_d = mark_q;
        spd_d = spd_q;
        out_d = '0;
        for (int i = 0; i < 2; i++) begin
            if (p2_q[i] == p3_q[i]) pLvl_d[i] = p3_q[i];
        end
        // Power-up lamp phase then health check
        case (pwr_q)
            P_OFFLAMP: begin
                if (!started_q) begin
                    tStart_d = 1'b1;
                    tLoad_d = TMR_W'(PWROFF_CYCLES);
                end else if (link.tmrDone) begin
                    pwr_d = P_HEALTH;
                    out_d[16] = 1'b1;
                end
            end
            P_HEALTH: if (healthDone) pwr_d = P_READY;
            default: ;
        endcase
        // Tape motion
        case (mot_q)
            M_COMP: if (link.tmrDone) mot_d = M_FWD;
            M_FWD: begin
                if (markerSeen) begin
                    mot_d = M_IDLE;
                end else if (footPulse) begin
                    feet_d = feet_q + 1'b1;
                    if (feet_q == FT_W'(OVERRUN_FEET - 1)) begin
                        mot_d = M_REV;
                    end
                end
            end
            M_REV: if (markerSeen) mot_d = M_IDLE;
            M_UNLOAD: if (tapeClear) mot_d = M_IDLE;
            default: ;
        endcase
        if (loadBusy && mot_d == M_IDLE) begin
            loaded_d = 1'b1;
            mark_d = 1'b1;
            spd_d = 1'b1;
            out_d[21] = 1'b1;
            if (pend_q) begin
                onLine_d = 1'b1;
                pend_d = 1'b0;
            end
        end
        // Operator switches; reset press outranks the rest
        if (ready) begin
            if (pRst) begin
                onLine_d = 1'b0;
                pend_d = 1'b0;
                mot_d = M_IDLE;
                err_d = 1'b0;
                done_d = 1'b0;
                diag_d = 1'b0;
                out_d[21] = 1'b0;
            end else if (pOn && !diag_q) begin
                if (loaded_q && mot_q == M_IDLE) onLine_d = 1'b1;
                else if (loadBusy) pend_d = 1'b1;
            end else if (pTest && !onLine_q && !diag_q) begin
                diag_d = 1'b1;
                test_d = TEST_FIRST;
            end else if (diag_q && pStep) begin
                test_d = bcdNext(test_q);
            end else if (diag_q && pExe) begin
                out_d[17] = 1'b1;
                done_d = 1'b0;
            end else if (diag_q && pSvc) begin
                out_d[18] = 1'b1;
                done_d = 1'b0;
            end else if (pLoad && !onLine_q && !diag_q && mot_q == M_IDLE) begin
                mark_d = 1'b0;
                feet_d = '0;
                if (loaded_q) begin
                    mot_d = M_REV;
                end else if (tapeThreaded) begin
                    mot_d = M_COMP;
                    tStart_d = 1'b1;
                    tLoad_d = TMR_W'(COMP_CYCLES);
                end
            end else if (pUnl && !onLine_q && !diag_q && mot_q == M_IDLE
                         && (loaded_q || tapeThreaded)) begin
                mot_d = M_UNLOAD;
                loaded_d = 1'b0;
                mark_d = 1'b0;
            end
        end
        // Events set after the clears so a same-cycle set survives
        if (faultEvt) begin
            err_d = 1'b1;
            errCode_d = faultCode;
        end
        if (hardEvt) begin
            hard_d = 1'b1;
            hardC_d = hardCode;
        end
        if (diagEnd) begin
            done_d = 1'b1;
            result_d = diagResult;
        end
        // Lamps and outputs, registered from the next state; host grants from the current state
        out_d[0] = onLine_d;
        out_d[1] = err_d || hard_d || done_d;
        out_d[2] = (pwr_d == P_HEALTH) || gcrMode;
        out_d[3] = diag_d;
        out_d[4] = (pwr_d == P_OFFLAMP);
        out_d[5] = (pwr_d != P_OFFLAMP);
        out_d[6] = (pwr_d == P_HEALTH) || !pLvl_d[1];
        out_d[7] = mark_d;
        out_d[8] = diag_d || out_d[1];
        out_d[9] = (mot_d != M_IDLE) || loaded_d;
        out_d[10] = (mot_d == M_FWD);
        out_d[11] = (mot_d == M_REV) || (mot_d == M_UNLOAD);
        out_d[12] = onLine_d;
        out_d[13] = onLine_q && hostWriteReq && ringOk;
        out_d[14] = onLine_q && hostReadReq;
        out_d[15] = spd_d;
        // Fault codes take the display over test numbers
        if (hard_d) disp_d = hardC_d;
        else if (err_d) disp_d = errCode_d;
        else if (done_d) disp_d = result_d;
        else if (diag_d) disp_d = test_d;
        else disp_d = CODE_NONE;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pwr_q <= P_OFFLAMP;
            mot_q <= M_IDLE;
            p1_q <= '0;
            p2_q <= '0;
            p3_q <= '0;
            pLvl_q <= '0;
            started_q <= 1'b0;
            tStart_q <= 1'b0;
            tLoad_q <= '0;
            feet_q <= '0;
            {onLine_q, diag_q, loaded_q, pend_q} <= 4'h0;
            {err_q, hard_q, done_q, mark_q, spd_q} <= 5'h00;
            errCode_q <= CODE_NONE;
            hardC_q <= CODE_NONE;
            result_q <= CODE_NONE;
            test_q <= TEST_FIRST;
            out_q <= 22'h000010;
            disp_q <= CODE_NONE;
        end else if (clkEn) begin
            pwr_q <= pwr_d;
            mot_q <= mot_d;
            p1_q <= {ringPin, markerPin};
            p2_q <= p1_q;
            p3_q <= p2_q;
            pLvl_q <= pLvl_d;
            started_q <= started_d;
            tStart_q <= tStart_d;
            tLoad_q <= tLoad_d;
            feet_q <= feet_d;
            {onLine_q, diag_q, loaded_q, pend_q} <=
                {onLine_d, diag_d, loaded_d, pend_d};
            {err_q, hard_q, done_q, mark_q, spd_q} <=
                {err_d, hard_d, done_d, mark_d, spd_d};
            errCode_q <= errCode_d;
            hardC_q <= hardC_d;
            result_q <= result_d;
            test_q <= test_d;
            out_q <= out_d;
            disp_q <= disp_d;
        end
    end

    assign {positionStart, speed25Sel} = {out_q[21], out_q[15]};
    assign {serviceStart, diagStart, healthStart} = out_q[18:16];
    assign {readGrant, writeGrant, hostCtlEn} = out_q[14:12];
    assign {motorRev, motorFwd, compressorOn} = out_q[11:9];
    assign {dispOn, lampTapeStart, lampWriteProtect} = out_q[8:6];
    assign {lampPowerOn, lampPowerOff, lampDiag} = out_q[5:3];
    assign {lampHighDensity, lampReset, lampOnLine} = out_q[2:0];
    assign testNum = test_q;
    assign dispCode = disp_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_online;
        clkEn && ready && pOn && !pRst && !diag_q && loaded_q
            && mot_q == M_IDLE |=> lampOnLine && hostCtlEn;
    endproperty
    a_online: assert property (p_online) else $error("no on-line");
    property p_lamp;
        lampOnLine |-> onLine_q && hostCtlEn;
    endproperty
    a_lamp: assert property (p_lamp) else $error("lamp mismatch");
    property p_reset;
        clkEn && ready && pRst && !faultEvt
            |=> !lampOnLine && !motorFwd && !motorRev && !err_q;
    endproperty
    a_reset: assert property (p_reset) else $error("reset failed");
    property p_hard;
        hard_q |=> hard_q && lampReset;
    endproperty
    a_hard: assert property (p_hard) else $error("hard fault lost");
    property p_test;
        clkEn && pTest && onLine_q && !diag_q |=> !diag_q && !lampDiag;
    endproperty
    a_test: assert property (p_test) else $error("test accepted");
    property p_step;
        clkEn && ready && diag_q && pStep && !pRst
            |=> testNum != $past(testNum);
    endproperty
    a_step: assert property (p_step) else $error("step stuck");
    property p_marker;
        clkEn && mot_q == M_FWD && markerSeen && !pRst
            |=> !motorFwd && loaded_q ##1 !clkEn || lampTapeStart;
    endproperty
    a_marker: assert property (p_marker) else $error("no stop");
    property p_comp;
        clkEn && mot_q == M_IDLE && mot_d == M_COMP
            |=> compressorOn && !motorFwd;
    endproperty
    a_comp: assert property (p_comp) else $error("load order");
    property p_write;
        $past(clkEn) && writeGrant |-> $past(ringOk) && $past(onLine_q);
    endproperty
    a_write: assert property (p_write) else $error("write no ring");
    property p_diaglamp;
        clkEn && diag_d |=> lampDiag && dispOn;
    endproperty
    a_diaglamp: assert property (p_diaglamp) else $error("diag lamp");
    c_load: cover property (loadBusy ##1 mot_q == M_IDLE && loaded_q);
    c_pend: cover property (pend_q ##[1:1000] lampOnLine);
    c_diag: cover property (pTest ##1 diag_q);
endmodule
`default_nettype wire

//--- tb/panel_model.sv
// Operator panel model: holds one switch closed, then opens it
`timescale 1ns/1ps
`default_nettype none
module panel_model
    import tape_panel_pkg::*;
#(
    parameter int HOLD = 12
) (
    input  wire logic              mclk,
    input  wire logic              pushGo,
    input  wire logic [2:0]        pushSel,
    output logic      [NUM_SW-1:0] swRaw
);
    int holdCnt = 0;
    initial swRaw = 8'h00;
    // Held past the debounce time so one push gives one press
    always @(posedge mclk) begin
        if (pushGo) begin
            swRaw <= 8'h01 << pushSel;
            holdCnt <= HOLD;
        end else if (holdCnt > 1) begin
            holdCnt <= holdCnt - 1;
        end else begin
            swRaw <= 8'h00;
            holdCnt <= 0;
        end
    end
endmodule
`default_nettype wire

//--- tb/tape_panel_sequencer_tb.sv
// Self-checking bench for the operator panel sequencer
`timescale 1ns/1ps
`default_nettype none
module tape_panel_sequencer_tb;
    import tape_panel_pkg::*;
    logic mclk = 0, rst = 1, clkEn = 1, markerPin = 0, ringPin = 0;
    logic tapeThreaded = 0, tapeClear = 0, footPulse = 0, gcrMode = 0;
    logic healthDone = 0, faultEvt = 0, hardEvt = 0, diagEnd = 0;
    logic hostWriteReq = 0, hostReadReq = 0, pushGo = 0;
    logic [2:0] pushSel = 3'h0;
    logic [7:0] faultCode = 8'h00, hardCode = 8'h00, diagResult = 8'h00;
    logic [NUM_SW-1:0] swRaw;
    logic lampOnLine, lampReset, lampHighDensity, lampDiag, lampPowerOff;
    logic lampPowerOn, lampWriteProtect, lampTapeStart, dispOn;
    logic compressorOn, motorFwd, motorRev, hostCtlEn, writeGrant;
    logic readGrant, healthStart, diagStart, serviceStart, speed25Sel;
    logic positionStart, sawDiag = 0, sawSvc = 0, sawPos = 0, sawHlt = 0;
    logic [7:0] dispCode, testNum;
    int badCount = 0, comparisons = 0, cycles = 0;

    tape_panel_sequencer #(.DB_CYCLES(4), .COMP_CYCLES(20),
        .PWROFF_CYCLES(10), .OVERRUN_FEET(3)) DUT (.*);
    panel_model PANEL (.mclk(mclk), .pushGo(pushGo), .pushSel(pushSel),
        .swRaw(swRaw));

    always #2 mclk = ~mclk;
    // Start pulses are one cycle wide, so latch them for later checks
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (diagStart) sawDiag <= 1;
        if (serviceStart) sawSvc <= 1;
        if (positionStart) sawPos <= 1;
        if (healthStart) sawHlt <= 1;
        if (cycles == 20000) begin
            badCount++;
            printVerdict();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            badCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        @(negedge mclk);
        s = 0;
        repeat (3) @(negedge mclk);
    endtask
    // Bounded wait; a miss shows up in the compare that follows
    task automatic waitHi(ref logic s);
        for (int i = 0; i < 300 && s !== 1'b1; i++) @(negedge mclk);
    endtask
    // No completion signal for a press: wait out press and release
    task automatic press(input int k);
        pushSel = k[2:0];
        pushGo = 1;
        @(negedge mclk);
        pushGo = 0;
        repeat (30) @(negedge mclk);
    endtask

    task t_power;
        chk(lampPowerOff, 1);
        waitHi(lampPowerOn);
        chk(lampPowerOff, 0);
        chk(lampWriteProtect, 1);
        chk(lampHighDensity, 1);
        pulse(healthDone);
        chk({lampPowerOn, sawHlt}, 8'h03);
        chk(lampHighDensity, 0);
        gcrMode = 1;
        repeat (3) @(negedge mclk);
        chk(lampHighDensity, 1);
        chk(lampWriteProtect, 1);
    endtask
    task t_load;
        tapeThreaded = 1;
        press(SW_LOADREW);
        chk(compressorOn, 1);
        waitHi(motorFwd);
        chk(motorFwd, 1);
        press(SW_ONLINE);
        repeat (3) pulse(footPulse);
        waitHi(motorRev);
        chk(motorRev, 1);
        chk(lampOnLine, 0);
        markerPin = 1;
        waitHi(lampTapeStart);
        // Pulse latch updates one edge after the pulse rises
        @(negedge mclk);
        chk({motorFwd, motorRev, speed25Sel, sawPos}, 8'h03);
        repeat (2) @(negedge mclk);
        chk({lampOnLine, hostCtlEn}, 8'h03);
    endtask
    task t_write;
        hostWriteReq = 1;
        hostReadReq = 1;
        repeat (8) @(negedge mclk);
        chk({writeGrant, readGrant}, 8'h01);
        ringPin = 1;
        repeat (8) @(negedge mclk);
        chk({writeGrant, readGrant}, 8'h03);
        chk(lampWriteProtect, 0);
        hostWriteReq = 0;
        press(SW_TEST);
        chk(lampDiag, 0);
    endtask
    task t_fault;
        faultCode = 8'h12;
        pulse(faultEvt);
        chk({lampReset, dispOn}, 8'h03);
        chk(dispCode, 8'h12);
        press(SW_RESET);
        chk({lampOnLine, hostCtlEn, lampReset}, 8'h00);
        // Loaded and idle: a direct on-line press is taken at once
        press(SW_ONLINE);
        chk({lampOnLine, hostCtlEn}, 8'h03);
        press(SW_RESET);
        chk(lampOnLine, 0);
    endtask
    task t_diag;
        press(SW_TEST);
        chk({lampDiag, dispOn}, 8'h03);
        chk(testNum, 8'h01);
        press(SW_STEP);
        chk(testNum, 8'h02);
        press(SW_EXECUTE);
        chk(sawDiag, 1);
        diagResult = 8'h07;
        pulse(diagEnd);
        chk(lampReset, 1);
        chk(dispCode, 8'h07);
        press(SW_SERVICE);
        chk(sawSvc, 1);
        press(SW_RESET);
        chk(lampDiag, 0);
    endtask
    task t_unload;
        press(SW_UNLOAD);
        chk(motorRev, 1);
        tapeClear = 1;
        repeat (3) @(negedge mclk);
        chk(motorRev, 0);
        hardCode = 8'h34;
        pulse(hardEvt);
        chk(dispCode, 8'h34);
        press(SW_RESET);
        chk(dispCode, 8'h34);
        // Reload with the marker already in view: forward stops at once
        tapeClear = 0;
        press(SW_LOADREW);
        waitHi(lampTapeStart);
        chk({motorFwd, lampTapeStart}, 8'h01);
    endtask

    task printVerdict;
        $display("comparisons=%0d badCount=%0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (6) @(negedge mclk);
        rst = 0;
        t_power();
        t_load();
        t_write();
        t_fault();
        t_diag();
        t_unload();
        printVerdict();
    end
endmodule
`default_nettype wire
